// *** src/i2c_slave_register_port.sv ***
// two-wire slave port giving an outside master byte access to the control registers
// assumes a register array beside it that answers reg_rdata_i combinationally
// for reg_addr_o, and pull-ups on both bus lines
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - data changes only while clock low
// - sda fall with clock high: start
// - sda rise with clock high: stop, idle
// - eight bits, msb first, then ack slot
// - transmitter releases, receiver holds ack low
// - own bus address is 0x2c
// - eighth address bit selects direction
// - ack only matching address, else ignore
// - write: pointer byte, then data stored
// - pointer increments after each written byte
// - read after pointer write and restart
// - master ack increments pointer, next byte
// - nack then stop ends read, release
// - repeated start restarts address reception
// - slave only, never drives clock
// - busy from start until stop
// - reading fault register clears fault flags
module i2c_slave_register_port (
    input  wire logic       clk_sys_i,
    input  wire logic       rst_n_i,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    input  wire logic [7:0] reg_rdata_i,
    output logic            sda_out_o,
    output logic            sda_oe_n_o,
    output logic [7:0]      reg_addr_o,
    output logic [7:0]      reg_wdata_o,
    output logic            reg_wr_o,
    output logic            reg_rd_o,
    output logic            fault_clear_o,
    output logic            bus_busy_o
);
    import i2c_port_pkg::*;

    logic        scl_f;
    logic        sda_f;
    logic        scl_rise;
    logic        scl_fall;
    logic        start_pulse;
    logic        stop_pulse;

    port_state_t state_reg,   state_next;
    logic [7:0]  rx_shift_reg, rx_shift_next;
    logic [3:0]  rx_cnt_reg,  rx_cnt_next;
    logic [7:0]  tx_shift_reg, tx_shift_next;
    logic [2:0]  tx_cnt_reg,  tx_cnt_next;
    logic [7:0]  ptr_reg,     ptr_next;
    logic [7:0]  wdata_reg,   wdata_next;
    logic        rw_reg,      rw_next;
    logic        ack_reg,     ack_next;
    logic        oe_n_reg,    oe_n_next;
    logic        busy_reg,    busy_next;
    logic        wr_reg,      wr_next;
    logic        rd_reg,      rd_next;
    logic        clr_reg,     clr_next;
    logic        sda_out_reg;

    // both lines see the same delay, so start and stop ordering survives filtering
    line_filter u_scl_filter (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .raw_i     (scl_i),
        .level_o   (scl_f)
    );

    line_filter u_sda_filter (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .raw_i     (sda_i),
        .level_o   (sda_f)
    );

    bus_events u_events (
        .clk_sys_i  (clk_sys_i),
        .rst_n_i    (rst_n_i),
        .scl_i      (scl_f),
        .sda_i      (sda_f),
        .scl_rise_o (scl_rise),
        .scl_fall_o (scl_fall),
        .start_o    (start_pulse),
        .stop_o     (stop_pulse)
    );

    wire        receiving  = (state_reg == ST_ADDR) || (state_reg == ST_PTR) ||
                             (state_reg == ST_WDATA);
    wire        byte_done  = scl_fall && (rx_cnt_reg == BITS_PER_BYTE);
    wire        addr_match = (rx_shift_reg[7:1] == DEV_ADDR) && busy_reg;
    wire        rw_bit     = rx_shift_reg[0];
    wire [7:0]  rx_shifted = {rx_shift_reg[6:0], sda_f};
    wire [7:0]  tx_shifted = {tx_shift_reg[6:0], 1'b0};
    wire [7:0]  ptr_inc    = 8'(ptr_reg + PTR_STEP);
    wire [3:0]  rx_cnt_inc = 4'(rx_cnt_reg + 4'h1);
    wire [2:0]  tx_cnt_inc = 3'(tx_cnt_reg + 3'h1);
    wire        tx_done    = (tx_cnt_reg == TX_LAST_BIT);
    wire        fault_read = (ptr_reg == FAULT_REG_ADDR);

    always_comb begin
        state_next    = state_reg;
        rx_shift_next = rx_shift_reg;
        rx_cnt_next   = rx_cnt_reg;
        tx_shift_next = tx_shift_reg;
        tx_cnt_next   = tx_cnt_reg;
        ptr_next      = ptr_reg;
        wdata_next    = wdata_reg;
        rw_next       = rw_reg;
        ack_next      = ack_reg;
        oe_n_next     = oe_n_reg;
        busy_next     = busy_reg;
        wr_next       = 1'b0;
        rd_next       = 1'b0;
        clr_next      = 1'b0;
        // an sda change while scl is high is always a start or stop, and either
        // one aborts whatever transfer is in flight
        if (start_pulse) begin
            state_next  = ST_ADDR;
            rx_cnt_next = 4'h0;
            oe_n_next   = 1'b1;
            busy_next   = 1'b1;
        end else if (stop_pulse) begin
            state_next = ST_IDLE;
            oe_n_next  = 1'b1;
            busy_next  = 1'b0;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    oe_n_next = 1'b1;
                end
                ST_ADDR, ST_PTR, ST_WDATA: begin
                    if (scl_rise) begin
                        rx_shift_next = rx_shifted;
                        rx_cnt_next   = rx_cnt_inc;
                    end else if (byte_done) begin
                        rx_cnt_next = 4'h0;
                        if (state_reg == ST_ADDR) begin
                            if (addr_match) begin
                                rw_next    = rw_bit;
                                oe_n_next  = 1'b0;
                                state_next = ST_ADDR_ACK;
                            end else begin
                                state_next = ST_IDLE;
                            end
                        end else if (state_reg == ST_PTR) begin
                            ptr_next   = rx_shift_reg;
                            oe_n_next  = 1'b0;
                            state_next = ST_PTR_ACK;
                        end else begin
                            wdata_next = rx_shift_reg;
                            wr_next    = 1'b1;
                            oe_n_next  = 1'b0;
                            state_next = ST_WACK;
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        if (rw_reg == RW_READ) begin
                            tx_shift_next = reg_rdata_i;
                            tx_cnt_next   = 3'h0;
                            oe_n_next     = reg_rdata_i[7];
                            state_next    = ST_RDATA;
                        end else begin
                            oe_n_next  = 1'b1;
                            state_next = ST_PTR;
                        end
                    end
                end
                ST_PTR_ACK: begin
                    if (scl_fall) begin
                        oe_n_next  = 1'b1;
                        state_next = ST_WDATA;
                    end
                end
                ST_WACK: begin
                    if (scl_fall) begin
                        oe_n_next  = 1'b1;
                        ptr_next   = ptr_inc;
                        state_next = ST_WDATA;
                    end
                end
                ST_RDATA: begin
                    if (scl_fall) begin
                        if (tx_done) begin
                            oe_n_next  = 1'b1;
                            state_next = ST_RACK;
                        end else begin
                            tx_shift_next = tx_shifted;
                            tx_cnt_next   = tx_cnt_inc;
                            oe_n_next     = tx_shift_reg[6];
                        end
                    end
                end
                ST_RACK: begin
                    if (scl_rise) begin
                        rd_next  = 1'b1;
                        clr_next = fault_read;
                        ack_next = ~sda_f;
                        if (!sda_f) begin
                            ptr_next = ptr_inc;
                        end
                    end else if (scl_fall) begin
                        if (ack_reg) begin
                            tx_shift_next = reg_rdata_i;
                            tx_cnt_next   = 3'h0;
                            oe_n_next     = reg_rdata_i[7];
                            state_next    = ST_RDATA;
                        end else begin
                            oe_n_next  = 1'b1;
                            state_next = ST_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg    <= ST_IDLE;
            rx_shift_reg <= 8'h00;
            rx_cnt_reg   <= 4'h0;
            tx_shift_reg <= 8'h00;
            tx_cnt_reg   <= 3'h0;
            ptr_reg      <= PTR_RESET;
            wdata_reg    <= 8'h00;
            rw_reg       <= 1'b0;
            ack_reg      <= 1'b0;
        end else begin
            state_reg    <= state_next;
            rx_shift_reg <= rx_shift_next;
            rx_cnt_reg   <= rx_cnt_next;
            tx_shift_reg <= tx_shift_next;
            tx_cnt_reg   <= tx_cnt_next;
            ptr_reg      <= ptr_next;
            wdata_reg    <= wdata_next;
            rw_reg       <= rw_next;
            ack_reg      <= ack_next;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            oe_n_reg    <= 1'b1;
            busy_reg    <= 1'b0;
            wr_reg      <= 1'b0;
            rd_reg      <= 1'b0;
            clr_reg     <= 1'b0;
            sda_out_reg <= 1'b0;
        end else begin
            oe_n_reg    <= oe_n_next;
            busy_reg    <= busy_next;
            wr_reg      <= wr_next;
            rd_reg      <= rd_next;
            clr_reg     <= clr_next;
            sda_out_reg <= 1'b0;
        end
    end

    // no clock output exists at all: the port can only stretch nothing and drive nothing
    // on scl, and it never makes its own start or stop
    assign sda_out_o     = sda_out_reg;
    assign sda_oe_n_o    = oe_n_reg;
    assign reg_addr_o    = ptr_reg;
    assign reg_wdata_o   = wdata_reg;
    assign reg_wr_o      = wr_reg;
    assign reg_rd_o      = rd_reg;
    assign fault_clear_o = clr_reg;
    assign bus_busy_o    = busy_reg;

    start_addr_a: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        start_pulse |=> (state_reg == ST_ADDR) && sda_oe_n_o && bus_busy_o)
        else $error("start did not restart address reception");

    stop_idle_a: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        stop_pulse |=> (state_reg == ST_IDLE) && sda_oe_n_o && !bus_busy_o)
        else $error("stop did not return to idle");

    idle_release_a: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (state_reg == ST_IDLE) |-> sda_oe_n_o && !sda_out_o)
        else $error("sda driven while idle");

    addr_miss_a: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (state_reg == ST_ADDR && byte_done && !start_pulse && !stop_pulse &&
         rx_shift_reg[7:1] != DEV_ADDR) |=> (state_reg == ST_IDLE) && sda_oe_n_o)
        else $error("foreign address was not ignored");

    ack_hold_a: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (state_reg == ST_ADDR_ACK || state_reg == ST_PTR_ACK || state_reg == ST_WACK)
        |-> !sda_oe_n_o)
        else $error("ack slot not held low");

    write_store_a: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (state_reg == ST_WDATA && byte_done && !start_pulse && !stop_pulse)
        |=> reg_wr_o && (reg_wdata_o == $past(rx_shift_reg)) && (state_reg == ST_WACK))
        else $error("data byte not stored");

    write_inc_a: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (state_reg == ST_WACK && scl_fall && !start_pulse && !stop_pulse)
        |=> (reg_addr_o == 8'($past(reg_addr_o) + 8'h01)))
        else $error("write pointer not incremented");

    read_inc_a: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (state_reg == ST_RACK && scl_rise && !sda_f && !start_pulse && !stop_pulse)
        |=> reg_rd_o && (reg_addr_o == 8'($past(reg_addr_o) + 8'h01)))
        else $error("read pointer not incremented on ack");

    fault_clr_a: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        fault_clear_o |-> reg_rd_o && ($past(reg_addr_o) == FAULT_REG_ADDR))
        else $error("fault clear without fault register read");

    nack_end_a: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (state_reg == ST_RACK && !ack_reg && scl_fall && !start_pulse && !stop_pulse)
        |=> (state_reg == ST_IDLE) ##1 sda_oe_n_o)
        else $error("sda not released after nack");

    rx_release_a: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        receiving |-> sda_oe_n_o)
        else $error("sda driven while master sends");

    free_release_a: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        !bus_busy_o |-> sda_oe_n_o)
        else $error("sda driven outside a transfer");

    rd_strobe_a: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        reg_rd_o |-> $past(state_reg == ST_RACK) && (state_reg == ST_RACK))
        else $error("read strobe outside ack slot");
endmodule : i2c_slave_register_port
`default_nettype wire

// *** src/i2c_port_pkg.sv ***
// constants, timing counts and state codes for the two-wire slave register port
// assumes a 125 MHz system clock and a bus master far slower than that clock
package i2c_port_pkg;

    localparam int unsigned SYS_CLK_PERIOD_NS = 8;
    // spikes shorter than this on either line are swallowed by the filter
    localparam int unsigned GLITCH_REJECT_NS  = 20;
    localparam int unsigned FILTER_LEN        =
        (GLITCH_REJECT_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;

    localparam logic [6:0] DEV_ADDR       = 7'h2c;
    localparam logic [7:0] FAULT_REG_ADDR = 8'h02;
    localparam logic [7:0] PTR_RESET      = 8'h00;
    localparam logic [7:0] PTR_STEP       = 8'h01;
    localparam logic [3:0] BITS_PER_BYTE  = 4'h8;
    localparam logic [2:0] TX_LAST_BIT    = 3'h7;
    localparam logic       RW_READ        = 1'b1;
    localparam logic       LINE_IDLE      = 1'b1;

    // gray codes along address -> pointer -> write data, and address -> read data
    typedef enum logic [3:0] {
        ST_IDLE     = 4'h0,
        ST_ADDR     = 4'h1,
        ST_ADDR_ACK = 4'h3,
        ST_PTR      = 4'h2,
        ST_PTR_ACK  = 4'h6,
        ST_WDATA    = 4'h7,
        ST_WACK     = 4'h5,
        ST_RDATA    = 4'hb,
        ST_RACK     = 4'ha
    } port_state_t;

endpackage : i2c_port_pkg

// *** src/line_filter.sv ***
// two-flop synchroniser plus run-length filter for one bus line
// assumes the line idles high and changes far slower than the system clock
`timescale 1ns/1ps
`default_nettype none
module line_filter (
    input  wire logic clk_sys_i,
    input  wire logic rst_n_i,
    input  wire logic raw_i,
    output logic      level_o
);
    import i2c_port_pkg::*;

    logic                  sync1_reg;
    logic                  sync2_reg;
    logic [FILTER_LEN-1:0] hist_reg;
    logic                  level_reg;
    wire                   all_high = &hist_reg;
    wire                   all_low  = ~|hist_reg;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync1_reg <= LINE_IDLE;
            sync2_reg <= LINE_IDLE;
            hist_reg  <= {FILTER_LEN{LINE_IDLE}};
            level_reg <= LINE_IDLE;
        end else begin
            sync1_reg <= raw_i;
            sync2_reg <= sync1_reg;
            hist_reg  <= {hist_reg[FILTER_LEN-2:0], sync2_reg};
            // level moves only after a full run of equal samples
            if (all_high) begin
                level_reg <= 1'b1;
            end else if (all_low) begin
                level_reg <= 1'b0;
            end
        end
    end

    assign level_o = level_reg;
endmodule : line_filter
`default_nettype wire

// *** src/bus_events.sv ***
// start, stop and clock edge pulses from the filtered bus lines
// assumes both inputs come from identical filters, so their relative timing holds
`timescale 1ns/1ps
`default_nettype none
module bus_events (
    input  wire logic clk_sys_i,
    input  wire logic rst_n_i,
    input  wire logic scl_i,
    input  wire logic sda_i,
    output logic      scl_rise_o,
    output logic      scl_fall_o,
    output logic      start_o,
    output logic      stop_o
);
    import i2c_port_pkg::*;

    logic scl_prev_reg;
    logic sda_prev_reg;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            scl_prev_reg <= LINE_IDLE;
            sda_prev_reg <= LINE_IDLE;
        end else begin
            scl_prev_reg <= scl_i;
            sda_prev_reg <= sda_i;
        end
    end

    wire scl_held_high = scl_prev_reg & scl_i;

    assign scl_rise_o = scl_i & ~scl_prev_reg;
    assign scl_fall_o = ~scl_i & scl_prev_reg;
    assign start_o    = scl_held_high & sda_prev_reg & ~sda_i;
    assign stop_o     = scl_held_high & ~sda_prev_reg & sda_i;
endmodule : bus_events
`default_nettype wire

// *** test/i2c_master_model.sv ***
// behavioural bus master: drives the serial clock, pulls the data line low
// assumes the bench resolves the data wire with a pull-up and returns it on sda_i
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
    input  wire logic clk_sys_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_low_o
);
    // stretches the low phase; a slow master only ever gives the port more time
    int extra_low = 0;

    initial begin
        scl_o     = 1'b1;
        sda_low_o = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask : wait_clk

    // data moves only with the clock low, sampled mid high phase
    task automatic put_bit(input logic b, output logic seen);
        wait_clk(7 + extra_low);
        sda_low_o = ~b;
        wait_clk(3);
        scl_o = 1'b1;
        wait_clk(5);
        seen = sda_i;
        wait_clk(5);
        scl_o = 1'b0;
    endtask : put_bit

    // start and repeated start: data falls with the clock high
    task automatic bus_start();
        wait_clk(5);
        sda_low_o = 1'b0;
        wait_clk(5);
        scl_o = 1'b1;
        wait_clk(10);
        sda_low_o = 1'b1;
        wait_clk(10);
        scl_o = 1'b0;
    endtask : bus_start

    // stop: data rises with the clock high, then the bus idles
    task automatic bus_stop();
        wait_clk(7);
        sda_low_o = 1'b1;
        wait_clk(3);
        scl_o = 1'b1;
        wait_clk(10);
        sda_low_o = 1'b0;
        wait_clk(10);
    endtask : bus_stop

    // eight bits msb first then the ack slot; as receiver a released slot
    // refuses the last byte, as transmitter the line is let go
    task automatic byte_io(input logic [7:0] tx, input logic ack_in,
                           output logic [7:0] rx, output logic ack_seen);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            put_bit(tx[i], s);
            rx[i] = s;
        end
        put_bit(~ack_in, s);
        ack_seen = ~s;
    endtask : byte_io

    // one-cycle dip with the clock high, shorter than the line filter
    task automatic sda_glitch();
        sda_low_o = 1'b1;
        wait_clk(1);
        sda_low_o = 1'b0;
        wait_clk(20);
    endtask : sda_glitch
endmodule : i2c_master_model
`default_nettype wire

// *** test/test_i2c_slave_register_port.sv ***
// self-checking bench for the two-wire slave register port
// assumes a pull-up on the data line and a byte array behind the port
`timescale 1ns/1ps
`default_nettype none
module test_i2c_slave_register_port;
    localparam int CYCLE_LIMIT = 40000;
    logic       clk_sys_i = 1'b0;
    logic       rst_n_i = 1'b0;
    logic       scl, sda_low, sda_line, sda_out_o, sda_oe_n_o;
    logic       reg_wr_o, reg_rd_o, fault_clear_o, bus_busy_o;
    logic [7:0] reg_addr_o, reg_wdata_o, reg_rdata_i;
    logic [7:0] mem [256];
    int         wr_cnt = 0, rd_cnt = 0, clr_cnt = 0, cycles = 0, busy_cnt = 0;
    int         n_mismatch = 0, n_tests = 0;

    always #4 clk_sys_i = ~clk_sys_i;
    // wired-and of both pull-downs against the pull-up
    assign sda_line    = (sda_low || (!sda_oe_n_o && !sda_out_o)) ? 1'b0 : 1'b1;
    assign reg_rdata_i = mem[reg_addr_o];

    i2c_master_model m (.clk_sys_i(clk_sys_i), .sda_i(sda_line),
                        .scl_o(scl), .sda_low_o(sda_low));
    i2c_slave_register_port dut (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .scl_i(scl), .sda_i(sda_line),
        .reg_rdata_i(reg_rdata_i), .sda_out_o(sda_out_o), .sda_oe_n_o(sda_oe_n_o),
        .reg_addr_o(reg_addr_o), .reg_wdata_o(reg_wdata_o), .reg_wr_o(reg_wr_o),
        .reg_rd_o(reg_rd_o), .fault_clear_o(fault_clear_o), .bus_busy_o(bus_busy_o));

    always @(posedge clk_sys_i) begin
        if (reg_wr_o === 1'b1) mem[reg_addr_o] <= reg_wdata_o;
        wr_cnt  <= wr_cnt + (reg_wr_o === 1'b1);
        rd_cnt  <= rd_cnt + (reg_rd_o === 1'b1);
        clr_cnt <= clr_cnt + (fault_clear_o === 1'b1);
        // a spike taken as start would raise busy for at least one cycle
        busy_cnt <= busy_cnt + (bus_busy_o === 1'b1);
        cycles  <= cycles + 1;
        if (cycles == CYCLE_LIMIT) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    task automatic check_bit(input logic got, input logic exp, input string what);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t %s: got %b exp %b", $time, what, got, exp);
        end
    endtask : check_bit

    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp,
                              input string what);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t %s: got %h exp %h", $time, what, got, exp);
        end
    endtask : check_byte

    task automatic wr_byte(input logic [7:0] tx, input logic exp_ack);
        logic [7:0] rx;
        logic       ack;
        m.byte_io(tx, 1'b0, rx, ack);
        check_bit(ack, exp_ack, "ack slot");
        check_byte(rx, tx, "line seen while master sends");
    endtask : wr_byte

    task automatic rd_byte(input logic ack_in, input logic [7:0] exp);
        logic [7:0] rx;
        logic       ack;
        m.byte_io(8'hff, ack_in, rx, ack);
        check_byte(rx, exp, "read data");
    endtask : rd_byte

    task automatic set_ptr(input logic [7:0] ptr);
        m.bus_start();
        wr_byte(8'h58, 1'b1);
        wr_byte(ptr, 1'b1);
    endtask : set_ptr

    task automatic t_write_burst();
        int w0;
        w0 = wr_cnt;
        set_ptr(8'h10);
        check_bit(bus_busy_o, 1'b1, "busy in transfer");
        wr_byte(8'ha5, 1'b1);
        wr_byte(8'h3c, 1'b1);
        wr_byte(8'h81, 1'b1);
        m.bus_stop();
        check_bit(bus_busy_o, 1'b0, "idle after stop");
        check_byte(mem[8'h10], 8'ha5, "first byte");
        check_byte(mem[8'h11], 8'h3c, "second byte");
        check_byte(mem[8'h12], 8'h81, "third byte");
        check_bit(wr_cnt - w0 == 3, 1'b1, "write strobes");
    endtask : t_write_burst

    task automatic t_read_burst();
        int r0, c0;
        r0 = rd_cnt;
        c0 = clr_cnt;
        set_ptr(8'h10);
        m.bus_start();
        wr_byte(8'h59, 1'b1);
        rd_byte(1'b1, 8'ha5);
        rd_byte(1'b1, 8'h3c);
        rd_byte(1'b0, 8'h81);
        m.bus_stop();
        check_bit(sda_oe_n_o, 1'b1, "released after read");
        check_byte(reg_addr_o, 8'h12, "no step on refused byte");
        // a read with no pointer write continues at the current pointer
        m.bus_start();
        wr_byte(8'h59, 1'b1);
        rd_byte(1'b0, 8'h81);
        m.bus_stop();
        check_bit(rd_cnt - r0 == 4, 1'b1, "read strobes");
        check_bit(clr_cnt == c0, 1'b1, "no clear off fault reg");
    endtask : t_read_burst

    task automatic t_wrong_addr();
        logic [6:0] bad [4] = '{7'h2d, 7'h6c, 7'h0c, 7'h2e};
        int         w0;
        w0 = wr_cnt;
        for (int i = 0; i < 4; i++) begin
            m.bus_start();
            wr_byte({bad[i], i[0]}, 1'b0);
            wr_byte(8'hff, 1'b0);
            m.bus_stop();
        end
        check_byte(reg_addr_o, 8'h12, "pointer kept");
        check_bit(wr_cnt == w0, 1'b1, "nothing written");
    endtask : t_wrong_addr

    task automatic t_fault_read();
        int c0, r0;
        set_ptr(8'h02);
        wr_byte(8'h5a, 1'b1);
        m.bus_stop();
        c0 = clr_cnt;
        r0 = rd_cnt;
        set_ptr(8'h02);
        m.bus_start();
        wr_byte(8'h59, 1'b1);
        rd_byte(1'b0, 8'h5a);
        m.bus_stop();
        check_bit(clr_cnt - c0 == 1, 1'b1, "fault clear once");
        check_bit(rd_cnt - r0 == 1, 1'b1, "one read strobe");
    endtask : t_fault_read

    task automatic t_wrap();
        set_ptr(8'hff);
        wr_byte(8'h11, 1'b1);
        wr_byte(8'h22, 1'b1);
        m.bus_stop();
        check_byte(mem[8'hff], 8'h11, "top register");
        check_byte(mem[8'h00], 8'h22, "pointer wraps");
    endtask : t_wrap

    task automatic t_abort();
        logic s;
        int   w0;
        w0 = wr_cnt;
        set_ptr(8'h20);
        m.put_bit(1'b1, s);
        m.put_bit(1'b0, s);
        m.put_bit(1'b1, s);
        m.bus_stop();
        check_bit(bus_busy_o, 1'b0, "idle after mid-byte stop");
        check_bit(sda_oe_n_o, 1'b1, "released after abort");
        set_ptr(8'h30);
        m.put_bit(1'b0, s);
        m.put_bit(1'b1, s);
        m.bus_start();
        wr_byte(8'h58, 1'b1);
        wr_byte(8'h31, 1'b1);
        wr_byte(8'h44, 1'b1);
        m.bus_stop();
        check_byte(mem[8'h31], 8'h44, "write after restart");
        check_bit(wr_cnt - w0 == 1, 1'b1, "aborted bytes dropped");
    endtask : t_abort

    task automatic t_glitch_and_slow();
        int b0;
        b0 = busy_cnt;
        m.sda_glitch();
        check_bit(busy_cnt == b0, 1'b1, "spike is no start");
        m.extra_low = 40;
        set_ptr(8'h40);
        wr_byte(8'h96, 1'b1);
        m.bus_stop();
        set_ptr(8'h40);
        m.bus_start();
        wr_byte(8'h59, 1'b1);
        rd_byte(1'b0, 8'h96);
        m.bus_stop();
        m.extra_low = 0;
    endtask : t_glitch_and_slow

    task automatic tally_and_finish();
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        for (int i = 0; i < 256; i++) mem[i] = 8'h00;
        repeat (16) @(negedge clk_sys_i);
        check_bit(sda_oe_n_o, 1'b1, "released in reset");
        rst_n_i = 1'b1;
        repeat (10) @(negedge clk_sys_i);
        check_bit(bus_busy_o, 1'b0, "idle after reset");
        check_byte(reg_addr_o, 8'h00, "pointer after reset");
        check_bit(sda_out_o, 1'b0, "open-drain data low");
        t_write_burst();
        t_read_burst();
        t_wrong_addr();
        t_fault_read();
        t_wrap();
        t_abort();
        t_glitch_and_slow();
        tally_and_finish();
    end
endmodule : test_i2c_slave_register_port
`default_nettype wire
